// ==== ara_top.sv ====
// Alarm relay, indicator, display page and menu control
`timescale 1ns/1ps
module ara_top #(
  parameter int DEBOUNCE_CYC = ara_pkg::DEBOUNCE_CYC,
  parameter int DWELL_CYC    = ara_pkg::DWELL_CYC,
  parameter int TIMEOUT_CYC  = ara_pkg::TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Front panel and external switches
  input  wire logic        menu_escape_switch,
  input  wire logic        up_switch,
  input  wire logic        down_switch,
  input  wire logic        accept_switch,
  input  wire logic        ext_switch,
  // Readings from the polling logic
  input  wire logic        reading_valid,
  input  wire logic [4:0]  reading_chan,
  input  wire logic [7:0]  reading_conc,
  input  wire logic        reading_fault,
  // Channel configuration writes
  input  wire logic        cfg_wr,
  input  wire logic [4:0]  cfg_chan,
  input  wire logic [1:0]  cfg_sel,
  input  wire logic [7:0]  cfg_data,
  // Relay behaviour, bit bank*4+level
  input  wire logic [31:0] relay_energized,
  input  wire logic [31:0] relay_latching,
  input  wire logic [31:0] relay_silenceable,
  // Page presence and module page alarms
  input  wire logic [6:0]  page_present,
  input  wire logic        xcvr_alarm,
  input  wire logic        relay_module_alarm,
  input  wire logic        aout_alarm,
  // Relay contacts, high while normally open contact is closed
  output logic      [31:0] relay_contact,
  // Front panel lamps
  output logic             led_alarm_level_one,
  output logic             led_alarm_level_two,
  output logic             led_alarm_level_three,
  output logic             led_fault,
  // Display and menu
  output logic      [2:0]  page_sel,
  output logic             menu_mode,
  output logic      [1:0]  menu_level,
  output logic      [2:0]  menu_pos,
  output logic             menu_inc,
  output logic             menu_dec,
  output logic             menu_confirm
);
  localparam int NC = ara_pkg::NUM_CHAN;
  localparam int NL = ara_pkg::NUM_LEVEL;
  localparam int NR = ara_pkg::NUM_RELAY;

  logic [ara_pkg::NUM_SW-1:0] sw_raw;                      // Switch pins
  logic [ara_pkg::NUM_SW-1:0] sw_press;                    // Swipe pulses
  logic [ara_pkg::CONC_W-1:0] thresh_reg [NC][ara_pkg::NUM_GAS_LVL];
  logic [NC-1:0]              asc_reg;                     // Ascending mode
  logic [2:0]                 bank_reg [NC];               // Assigned bank
  logic [NL-1:0]              chan_alarm_reg [NC];         // Per-channel levels
  logic [NR-1:0]              cond;                        // Bank level condition
  logic [NR-1:0]              act_reg, act_next;           // Relay active
  logic [NR-1:0]              sil_reg, sil_next;           // Relay silenced
  logic [NR-1:0]              drive_next;                  // Relay driven, before energized inversion
  logic [NL-1:0]              led_next;                    // Lamp values
  logic                       req;                         // Reset and acknowledge
  logic [6:0]                 alarm_mask;                  // Pages with alarms
  logic                       multi;                       // More than one
  ara_pkg::ara_disp_type      state_reg;
  logic [ara_pkg::TIMER_W-1:0] dwell_reg;                  // Page dwell timer
  logic [ara_pkg::TIMER_W-1:0] manual_reg;                 // Inactivity timer

  // Next present page in the chosen direction, current page if none
  function automatic logic [2:0] next_page(input logic [2:0] cur, input logic [6:0] mask, input logic up);
    logic [2:0] res;
    int         idx;
    res = cur;
    for (int k = ara_pkg::NUM_PAGE; k >= 1; k--) begin
      idx = up ? (int'(cur) + k) % ara_pkg::NUM_PAGE : (int'(cur) + ara_pkg::NUM_PAGE - k) % ara_pkg::NUM_PAGE;
      if (mask[idx]) begin
        res = idx[2:0];
      end
    end
    return res;
  endfunction

  // One debouncer per switch
  assign sw_raw = {ext_switch, accept_switch, down_switch, up_switch, menu_escape_switch};
  for (genvar g = 0; g < ara_pkg::NUM_SW; g++) begin : g_sw
    ara_debounce #(.DEB_CYC(DEBOUNCE_CYC)) u_deb (
      .clk  (clk),
      .rst  (rst),
      .pin  (sw_raw[g]),
      .press(sw_press[g])
    );
  end

  // Channel thresholds, direction and bank; index width caps channels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NC; c++) begin
        for (int l = 0; l < ara_pkg::NUM_GAS_LVL; l++) begin
          thresh_reg[c][l] <= ara_pkg::THRESH_RST;
        end
        bank_reg[c] <= 3'h0;
      end
      asc_reg <= '1;
    end else if (cfg_wr) begin
      if (cfg_sel == ara_pkg::CFG_BANK_DIR) begin
        bank_reg[cfg_chan] <= cfg_data[2:0];
        asc_reg[cfg_chan]  <= cfg_data[3];
      end else begin
        thresh_reg[cfg_chan][cfg_sel] <= cfg_data;
      end
    end
  end

  // Level evaluation, frozen while the menu is open
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NC; c++) begin
        chan_alarm_reg[c] <= '0;
      end
    end else if (reading_valid && state_reg != ara_pkg::ARA_MENU) begin
      for (int l = 0; l < ara_pkg::NUM_GAS_LVL; l++) begin
        chan_alarm_reg[reading_chan][l] <= asc_reg[reading_chan] ?
          (reading_conc > thresh_reg[reading_chan][l]) : (reading_conc < thresh_reg[reading_chan][l]);
      end
      chan_alarm_reg[reading_chan][ara_pkg::LVL_FAULT] <= reading_fault;
    end
  end

  // Any channel of a bank fires that level on the whole bank
  always_comb begin
    cond = '0;
    for (int c = 0; c < NC; c++) begin
      for (int l = 0; l < NL; l++) begin
        cond[int'(bank_reg[c]) * NL + l] |= chan_alarm_reg[c][l];
      end
    end
  end

  // Either switch source; accept only outside the menu
  assign req = (sw_press[ara_pkg::SW_ACCEPT] && state_reg != ara_pkg::ARA_MENU)
             || sw_press[ara_pkg::SW_EXT];

  // Per-relay latch and silence; each relay has its own three settings
  always_comb begin
    led_next = '0;
    for (int i = 0; i < NR; i++) begin
      // Latch holds until a reset finds the cause gone
      act_next[i] = cond[i] || (act_reg[i] && relay_latching[i] && !req);
      // Silence only silenceable relays, cleared when the relay drops
      sil_next[i] = act_next[i] && (sil_reg[i] || (req && relay_silenceable[i] && act_reg[i]));
      drive_next[i] = act_next[i] && !sil_next[i];
      led_next[i % NL] |= drive_next[i];
    end
  end

  // Relay state and contact sense
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_reg       <= '0;
      sil_reg       <= '0;
      relay_contact <= '0;  // Open until the first edge, the fail-safe side
    end else begin
      act_reg       <= act_next;
      sil_reg       <= sil_next;
      relay_contact <= drive_next ^ relay_energized;
    end
  end

  // Lamps follow the silenced relay outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {led_fault, led_alarm_level_three, led_alarm_level_two, led_alarm_level_one} <= '0;
    end else begin
      {led_fault, led_alarm_level_three, led_alarm_level_two, led_alarm_level_one} <= led_next;
    end
  end

  // Pages holding an alarm or fault
  always_comb begin
    alarm_mask = {aout_alarm, relay_module_alarm, xcvr_alarm, 4'h0};
    for (int c = 0; c < NC; c++) begin
      alarm_mask[c / ara_pkg::CHAN_PER_PAGE] |= |chan_alarm_reg[c];
    end
    alarm_mask = alarm_mask & page_present;
  end
  assign multi = |(alarm_mask & (alarm_mask - 7'h01));

  // Dwell timer paces automatic page cycling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dwell_reg <= '0;
    end else if (dwell_reg == '0) begin
      dwell_reg <= ara_pkg::TIMER_W'(DWELL_CYC - 1);
    end else begin
      dwell_reg <= dwell_reg - 1'b1;
    end
  end

  // Display mode, page selection and menu navigation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= ara_pkg::ARA_AUTO;
      page_sel     <= ara_pkg::PAGE_RST;
      manual_reg   <= '0;
      menu_mode    <= 1'b0;
      menu_level   <= 2'h0;
      menu_pos     <= 3'h0;
      menu_inc     <= 1'b0;
      menu_dec     <= 1'b0;
      menu_confirm <= 1'b0;
    end else begin
      menu_inc     <= 1'b0;
      menu_dec     <= 1'b0;
      menu_confirm <= 1'b0;
      unique case (state_reg)
        ara_pkg::ARA_AUTO, ara_pkg::ARA_MANUAL: begin
          if (sw_press[ara_pkg::SW_MENU]) begin
            state_reg  <= ara_pkg::ARA_MENU;
            menu_mode  <= 1'b1;
            menu_level <= 2'h1;
            menu_pos   <= 3'h0;
          end else if (sw_press[ara_pkg::SW_UP] || sw_press[ara_pkg::SW_DOWN]) begin
            state_reg  <= ara_pkg::ARA_MANUAL;
            page_sel   <= next_page(page_sel, page_present, sw_press[ara_pkg::SW_UP]);
            manual_reg <= ara_pkg::TIMER_W'(TIMEOUT_CYC - 1);
          end else if (state_reg == ara_pkg::ARA_MANUAL) begin
            if (manual_reg == '0) begin
              state_reg <= ara_pkg::ARA_AUTO;
            end else begin
              manual_reg <= manual_reg - 1'b1;
            end
          end else if (alarm_mask != '0 && !multi) begin
            page_sel <= next_page(page_sel, alarm_mask, 1'b1);
          end else if (dwell_reg == '0) begin
            // Several alarms cycle alarm pages; none cycles sensor pages
            page_sel <= next_page(page_sel, multi ? alarm_mask : (page_present & ara_pkg::SENSOR_PAGES), 1'b1);
          end
        end
        ara_pkg::ARA_MENU: begin
          if (sw_press[ara_pkg::SW_MENU]) begin
            menu_pos <= 3'h0;
            if (menu_level == 2'h1) begin
              state_reg  <= ara_pkg::ARA_AUTO;
              menu_mode  <= 1'b0;
              menu_level <= 2'h0;
            end else begin
              menu_level <= menu_level - 2'h1;
            end
          end else if (sw_press[ara_pkg::SW_ACCEPT]) begin
            menu_confirm <= 1'b1;
            if (menu_level != ara_pkg::MENU_MAX) begin
              menu_level <= menu_level + 2'h1;
              menu_pos   <= 3'h0;
            end
          end else if (sw_press[ara_pkg::SW_UP]) begin
            menu_pos <= menu_pos - 3'h1;
            menu_inc <= 1'b1;
          end else if (sw_press[ara_pkg::SW_DOWN]) begin
            menu_pos <= menu_pos + 3'h1;
            menu_dec <= 1'b1;
          end
        end
      endcase
    end
  end

  // Checks on relay, display and menu behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_idle_energized;
    !act_reg[0] && $past(relay_energized[0]) && !$past(rst) |-> relay_contact[0];
  endproperty
  a_idle_energized: assert property (p_idle_energized) else $error("energized idle contact open");
  property p_idle_deenergized;
    !act_reg[0] && !$past(relay_energized[0]) |-> !relay_contact[0];
  endproperty
  a_idle_deenergized: assert property (p_idle_deenergized) else $error("de-energized idle contact closed");
  property p_ack_silences;
    req && act_reg[0] && relay_silenceable[0] |=> sil_reg[0] || !act_reg[0];
  endproperty
  a_ack_silences: assert property (p_ack_silences) else $error("acknowledge did not silence");
  property p_nonsil_holds;
    cond[0] && !relay_silenceable[0] && !sil_reg[0] |=> act_reg[0] && !sil_reg[0];
  endproperty
  a_nonsil_holds: assert property (p_nonsil_holds) else $error("non-silenceable relay dropped");
  property p_reset_release;
    req && !cond[0] |=> !act_reg[0];
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset left relay latched");
  property p_nonlatch_drop;
    !relay_latching[0] && !cond[0] |=> !act_reg[0];
  endproperty
  a_nonlatch_drop: assert property (p_nonlatch_drop) else $error("non-latching relay held");
  property p_fire;
    cond[0] |=> act_reg[0];
  endproperty
  a_fire: assert property (p_fire) else $error("condition did not fire relay");
  property p_menu_no_req;
    state_reg == ara_pkg::ARA_MENU && !sw_press[ara_pkg::SW_EXT] |-> !req;
  endproperty
  a_menu_no_req: assert property (p_menu_no_req) else $error("accept requested reset in menu");
  property p_menu_enter;
    state_reg == ara_pkg::ARA_AUTO && sw_press[ara_pkg::SW_MENU] |=> menu_mode && menu_level == 2'h1;
  endproperty
  a_menu_enter: assert property (p_menu_enter) else $error("menu not entered");
  property p_menu_frozen;
    state_reg == ara_pkg::ARA_MENU |=> $stable(chan_alarm_reg[0]);
  endproperty
  a_menu_frozen: assert property (p_menu_frozen) else $error("alarm updated in menu");
  property p_timeout_back;
    state_reg == ara_pkg::ARA_MANUAL && manual_reg == '0 && sw_press == '0 |=> state_reg == ara_pkg::ARA_AUTO;
  endproperty
  a_timeout_back: assert property (p_timeout_back) else $error("manual timeout not left");

  c_silenced: cover property (cond[0] && sil_reg[0]);
  c_cycling: cover property (multi && state_reg == ara_pkg::ARA_AUTO && $changed(page_sel));
  c_timeout: cover property (state_reg == ara_pkg::ARA_MANUAL ##1 state_reg == ara_pkg::ARA_AUTO);
  c_menu_back: cover property (menu_level == 2'h2 ##1 menu_level == 2'h1);
endmodule

// ==== ara_pkg.sv ====
// Shared constants for the alarm relay and annunciation control block
package ara_pkg;
  // Sizes of the channel, level, bank and page structure
  localparam int NUM_CHAN      = 32;  // Attached field devices at most
  localparam int CHAN_PER_PAGE = 8;   // Channels shown on one group page
  localparam int NUM_GAS_LVL   = 3;   // Gas alarm levels one to three
  localparam int NUM_LEVEL     = 4;   // Gas levels plus fault
  localparam int LVL_FAULT     = 3;   // Index of the fault level
  localparam int NUM_BANK      = 8;   // Relay banks
  localparam int NUM_RELAY     = 32;  // Bank times level
  localparam int CONC_W        = 8;   // Concentration reading width
  localparam int NUM_PAGE      = 7;   // Group pages
  localparam int NUM_SW        = 5;   // Switch inputs
  localparam int TIMER_W       = 30;  // Wide enough for the page timeout
  localparam int DEB_W         = 20;  // Wide enough for the debounce time

  // Switch positions in the debounced press vector
  localparam int SW_MENU   = 0;
  localparam int SW_UP     = 1;
  localparam int SW_DOWN   = 2;
  localparam int SW_ACCEPT = 3;
  localparam int SW_EXT    = 4;

  // Page numbers: 0..3 sensor groups, then the module pages
  localparam logic [2:0] PAGE_XCVR   = 3'h4;
  localparam logic [2:0] PAGE_RELAY  = 3'h5;
  localparam logic [2:0] PAGE_AOUT   = 3'h6;
  localparam logic [6:0] SENSOR_PAGES = 7'h0f;

  // Configuration select codes
  localparam logic [1:0] CFG_BANK_DIR = 2'h3;  // Data[2:0] bank, data[3] ascending

  // Values after reset, and the deepest menu level
  localparam logic [CONC_W-1:0] THRESH_RST = 8'hff;
  localparam logic [2:0]        PAGE_RST   = 3'h0;
  localparam logic [1:0]        MENU_MAX   = 2'h3;

  // Timing
  localparam int CLK_HZ      = 40_000_000;
  localparam int TIMEOUT_S   = 15;   // Manual page selection timeout
  localparam int DWELL_S     = 2;    // Time on each page while cycling
  localparam int DEBOUNCE_MS = 20;   // Switch settling time
  localparam int TIMEOUT_CYC  = TIMEOUT_S * CLK_HZ;
  localparam int DWELL_CYC    = DWELL_S * CLK_HZ;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);

  // Display and menu states
  typedef enum logic [1:0] {
    ARA_AUTO,
    ARA_MANUAL,
    ARA_MENU
  } ara_disp_type;
endpackage

// ==== ara_debounce.sv ====
// Switch synchroniser, debouncer and press edge detector
`timescale 1ns/1ps
module ara_debounce #(
  parameter int DEB_CYC = ara_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Raw switch, high while the magnet is present
  input  wire logic pin,
  // One-cycle pulse per swipe
  output logic      press
);
  logic                      sync1_reg;   // First stage, read only by second
  logic                      sync2_reg;   // Safe to use
  logic                      stable_reg;  // Debounced level
  logic [ara_pkg::DEB_W-1:0] cnt_reg;     // Settling counter

  // Two-stage synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
    end
  end

  // Level must hold for the full settling time before it is believed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg    <= '0;
      stable_reg <= 1'b0;
      press      <= 1'b0;
    end else begin
      press <= 1'b0;
      if (sync2_reg == stable_reg) begin
        cnt_reg <= '0;
      end else if (cnt_reg == ara_pkg::DEB_W'(DEB_CYC - 1)) begin
        cnt_reg    <= '0;
        stable_reg <= sync2_reg;
        press      <= sync2_reg;  // Only the closing edge counts
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule

// ==== ara_panel_model.sv ====
// Operator model: swipes a magnet over one panel or external switch
`timescale 1ns/1ps
module ara_panel_model #(
  parameter int HOLD = 10  // Cycles the magnet stays on the marker
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Swipe request from the bench
  input  wire logic       swipe,
  input  wire logic [2:0] swipe_sel,
  // Switch pins, high while the magnet is present
  output logic      [4:0] pins
);
  logic [7:0] hold_reg;  // Cycles left with the magnet present
  logic [2:0] sel_reg;   // Switch being swiped

  // Magnet held briefly, then removed; one request gives one swipe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_reg <= 8'h00;
      sel_reg  <= 3'h0;
    end else if (swipe && hold_reg == 8'h00) begin
      hold_reg <= 8'(HOLD);
      sel_reg  <= swipe_sel;
    end else if (hold_reg != 8'h00) begin
      hold_reg <= hold_reg - 8'h01;
    end
  end

  // Released pins fall to the pull-down level, never hold a stale value
  assign pins = (hold_reg != 8'h00) ? (5'h01 << sel_reg) : 5'h00;
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the alarm relay and annunciation block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  logic        clk = 1'b0;               // 40 MHz clock
  logic        rst = 1'b1;               // Async reset
  logic        swipe = 1'b0;             // Swipe request to the operator
  logic [2:0]  swipe_sel = 3'h0;         // Which switch to swipe
  logic [4:0]  pins;                     // Switch pins from the operator
  logic        reading_valid = 1'b0;     // Reading strobe
  logic [4:0]  reading_chan = 5'h00;     // Reading channel
  logic [7:0]  reading_conc = 8'h00;     // Reading concentration
  logic        cfg_wr = 1'b0;            // Config strobe
  logic [4:0]  cfg_chan = 5'h00;         // Config channel
  logic [1:0]  cfg_sel = 2'h0;           // Config select
  logic [7:0]  cfg_data = 8'h00;         // Config data
  logic        reading_fault = 1'b0;     // Reading fault flag
  // Bank 0: level 0 energized, level 1 latching, level 2 silenceable
  logic [31:0] relay_energized = 32'h0000_0001;
  logic [31:0] relay_latching = 32'h0000_0002;
  logic [31:0] relay_silenceable = 32'h0000_0004;
  logic [6:0]  page_present = 7'h0f;     // Sensor group pages only
  logic        xcvr_alarm = 1'b0;        // Module page alarms
  logic        relay_module_alarm = 1'b0;
  logic        aout_alarm = 1'b0;
  logic [31:0] relay_contact;            // Relay contacts
  logic        led1, led2, led3, ledf;   // Front panel lamps
  logic [2:0]  page_sel, menu_pos;       // Display page and menu position
  logic [1:0]  menu_level;               // Menu depth
  logic        menu_mode, m_inc, m_dec, m_conf;
  int          n_mismatch = 0;           // Mismatch count
  int          n_compared = 0;           // Comparison count
  int          c_conf, c_inc, c_dec;     // Menu pulses seen in one swipe

  // Clock generator
  always #12.5 clk = ~clk;

  // Operator at the switches
  ara_panel_model #(.HOLD(10)) partner (.clk(clk), .rst(rst), .swipe(swipe), .swipe_sel(swipe_sel), .pins(pins));

  // Short counts keep the run brief; expectations follow these values
  ara_top #(.DEBOUNCE_CYC(4), .DWELL_CYC(20), .TIMEOUT_CYC(50)) uut (
    .clk(clk), .rst(rst),
    .menu_escape_switch(pins[0]), .up_switch(pins[1]), .down_switch(pins[2]),
    .accept_switch(pins[3]), .ext_switch(pins[4]),
    .reading_valid(reading_valid), .reading_chan(reading_chan), .reading_conc(reading_conc),
    .reading_fault(reading_fault), .cfg_wr(cfg_wr), .cfg_chan(cfg_chan), .cfg_sel(cfg_sel), .cfg_data(cfg_data),
    .relay_energized(relay_energized), .relay_latching(relay_latching), .relay_silenceable(relay_silenceable),
    .page_present(page_present), .xcvr_alarm(xcvr_alarm), .relay_module_alarm(relay_module_alarm),
    .aout_alarm(aout_alarm),
    .relay_contact(relay_contact), .led_alarm_level_one(led1), .led_alarm_level_two(led2),
    .led_alarm_level_three(led3), .led_fault(ledf), .page_sel(page_sel), .menu_mode(menu_mode),
    .menu_level(menu_level), .menu_pos(menu_pos), .menu_inc(m_inc), .menu_dec(m_dec), .menu_confirm(m_conf));

  // Wait a number of falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One configuration write
  task automatic cfg(input logic [4:0] ch, input logic [1:0] sel, input logic [7:0] d);
    cfg_wr = 1'b1;
    cfg_chan = ch;
    cfg_sel = sel;
    cfg_data = d;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(1);
  endtask

  // One reading from one distinct, correctly addressed channel
  task automatic rd(input logic [4:0] ch, input logic [7:0] conc);
    reading_valid = 1'b1;
    reading_chan = ch;
    reading_conc = conc;
    cyc(1);
    reading_valid = 1'b0;
    cyc(3);
  endtask

  // One swipe, counting menu pulses until press and release have settled
  task automatic sw(input logic [2:0] sel);
    c_conf = 0;
    c_inc = 0;
    c_dec = 0;
    swipe = 1'b1;
    swipe_sel = sel;
    cyc(1);
    swipe = 1'b0;
    repeat (30) begin
      cyc(1);
      c_conf += int'(m_conf !== 1'b0);
      c_inc += int'(m_inc !== 1'b0);
      c_dec += int'(m_dec !== 1'b0);
    end
  endtask

  // Idle contacts: energized closed, de-energized open, lamps dark
  task automatic t_idle;
    `CHK("contacts", 32'h0000_0001, relay_contact)
    `CHK("lamps", 4'h0, {led1, led2, led3, ledf})
    $display("test idle done");
  endtask

  // Strict thresholds, ascending and descending, bank fan-out
  task automatic t_alarm;
    cfg(5'h00, 2'h0, 8'h40);
    cfg(5'h00, 2'h1, 8'h50);
    cfg(5'h00, 2'h2, 8'h60);
    cfg(5'h01, 2'h3, 8'h01);   // Channel 1 in bank 1, descending
    cfg(5'h01, 2'h0, 8'h20);
    cfg(5'h01, 2'h1, 8'h00);   // Upper levels never trip when descending
    cfg(5'h01, 2'h2, 8'h00);
    rd(5'h00, 8'h40);
    `CHK("at threshold", 32'h0000_0001, relay_contact)
    rd(5'h00, 8'h55);
    `CHK("asc alarm", 32'h0000_0002, relay_contact)
    `CHK("lamps", 4'hc, {led1, led2, led3, ledf})
    rd(5'h01, 8'h10);
    `CHK("desc alarm", 32'h0000_0012, relay_contact)
    rd(5'h01, 8'h30);
    `CHK("desc clear", 32'h0000_0002, relay_contact)
    $display("test alarm done");
  endtask

  // Single alarm page, manual step, timeout back to alarm page
  task automatic t_page;
    `CHK("alarm page", 3'h0, page_sel)
    sw(3'h1);
    `CHK("manual page", 3'h1, page_sel)
    cyc(20);
    `CHK("still manual", 3'h1, page_sel)
    cyc(20);
    `CHK("resumed page", 3'h0, page_sel)
    $display("test page done");
  endtask

  // Non-latching drops, latching held until external reset
  task automatic t_latch;
    rd(5'h00, 8'h00);
    `CHK("latched", 32'h0000_0003, relay_contact)
    `CHK("lamps", 4'h4, {led1, led2, led3, ledf})
    sw(3'h4);
    `CHK("released", 32'h0000_0001, relay_contact)
    $display("test latch done");
  endtask

  // Acknowledge silences only silenceable, present cause keeps latch
  task automatic t_silence;
    rd(5'h00, 8'h65);
    `CHK("three levels", 32'h0000_0006, relay_contact)
    sw(3'h3);
    `CHK("confirm pulses", 0, c_conf)
    `CHK("silenced", 32'h0000_0002, relay_contact)
    `CHK("lamps", 4'hc, {led1, led2, led3, ledf})
    rd(5'h00, 8'h00);
    `CHK("after clear", 32'h0000_0003, relay_contact)
    sw(3'h4);
    `CHK("reset", 32'h0000_0001, relay_contact)
    $display("test silence done");
  endtask

  // Module page alarms: absent pages never shown, one page held, two cycled
  task automatic t_cycle;
    logic seen0, seen4, other;
    seen0 = 1'b0;
    seen4 = 1'b0;
    other = 1'b0;
    page_present = 7'h1f;
    xcvr_alarm = 1'b1;
    relay_module_alarm = 1'b1;
    aout_alarm = 1'b1;
    cyc(3);
    `CHK("module page", 3'h4, page_sel)
    reading_fault = 1'b1;
    rd(5'h02, 8'h00);
    `CHK("fault contact", 32'h0000_0009, relay_contact)
    `CHK("fault lamp", 4'h1, {led1, led2, led3, ledf})
    repeat (45) begin
      cyc(1);
      seen0 |= (page_sel === 3'h0);
      seen4 |= (page_sel === 3'h4);
      other |= (page_sel !== 3'h0 && page_sel !== 3'h4);
    end
    `CHK("cycled page 0", 1'b1, seen0)
    `CHK("cycled page 4", 1'b1, seen4)
    `CHK("other page", 1'b0, other)
    reading_fault = 1'b0;
    rd(5'h02, 8'h00);
    {page_present, xcvr_alarm, relay_module_alarm, aout_alarm} = {7'h0f, 3'h0};
    `CHK("fault clear", 32'h0000_0001, relay_contact)
    `CHK("lamps", 4'h0, {led1, led2, led3, ledf})
    $display("test cycle done");
  endtask

  // Menu entry, frozen readings, confirm, up, down, escape
  task automatic t_menu;
    sw(3'h0);
    `CHK("menu mode", 1'b1, menu_mode)
    `CHK("menu level", 2'h1, menu_level)
    rd(5'h00, 8'h65);
    `CHK("frozen", 32'h0000_0001, relay_contact)
    sw(3'h3);
    `CHK("confirm", 1, c_conf)
    `CHK("level two", 2'h2, menu_level)
    sw(3'h1);
    `CHK("inc", 1, c_inc)
    `CHK("pos up", 3'h7, menu_pos)
    sw(3'h2);
    `CHK("dec", 1, c_dec)
    `CHK("pos down", 3'h0, menu_pos)
    sw(3'h0);
    `CHK("back", 2'h1, menu_level)
    sw(3'h0);
    `CHK("main", 1'b0, menu_mode)
    $display("test menu done");
  endtask

  // Counts, verdict and end of run
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    cyc(4);
    rst = 1'b0;
    cyc(10);
    t_idle();
    t_alarm();
    t_page();
    t_latch();
    t_silence();
    t_cycle();
    t_menu();
    close_out();
  end

  // Watchdog well beyond the roughly 470 cycles the tests need
  initial begin
    cyc(5000);
    n_mismatch++;
    close_out();
  end
endmodule
